/* File: tb/swc_config_regs_tb.sv */
// Self-checking bench for the switch input configuration registers.
// Assumes swc_spi_master drives the serial link in mode 0.
`default_nettype none

module swc_config_regs_tb
   import swc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PULSE = 5;      // Short interrupt pulse for the run
   localparam int LIMIT = 90000;  // Cycle ceiling for a hung run

   logic                        clk, reset_n, sclkPin, csPin_n, mosiPin;
   logic                        misoOut, misoOe, irqEvent, lowPowerMode;
   logic                        faultEvent, faultPresent;
   logic                        logicRailOk, wakePin_n, pollWindow;
   logic                        wakeReq, irqPin_n, ovGuardOff;
   logic [1:0]                  muxSource;
   logic [NUM_PROG-1:0]         polarity;
   logic [8*NUM_PROG-1:0]       progSrcSel;
   logic [8*NUM_GND-1:0]        gndSrcSel;
   logic [NUM_PROG+NUM_GND-1:0] pollSample;
   logic [23:0]                 regv [1:8];  // Expected contents
   logic [31:0]                 rsp;
   int                          errorCnt, cmpCount, cycCnt, wakeCnt;

   ////////////////////////////////////////
   always #2.5 clk = ~clk;

   // Fault inputs are driven so the summary flags can be exercised
   swc_config_regs #(.PULSE_CYCLES(PULSE)) uut (
      .clk(clk), .reset_n(reset_n), .sclkPin(sclkPin),
      .csPin_n(csPin_n), .mosiPin(mosiPin), .misoOut(misoOut),
      .misoOe(misoOe), .faultEvent(faultEvent),
      .faultPresent(faultPresent),
      .irqEvent(irqEvent), .lowPowerMode(lowPowerMode),
      .logicRailOk(logicRailOk), .wakePin_n(wakePin_n),
      .pollWindow(pollWindow), .wakeReq(wakeReq), .irqPin_n(irqPin_n),
      .ovGuardOff(ovGuardOff), .muxSource(muxSource),
      .polarity(polarity), .progSrcSel(progSrcSel),
      .gndSrcSel(gndSrcSel), .pollSample(pollSample));

   swc_spi_master mst (.clk(clk), .misoOut(misoOut), .sclkPin(sclkPin),
      .csPin_n(csPin_n), .mosiPin(mosiPin));

   // Count wake pulses and cut a hung run short
   always @(posedge clk) begin
      cycCnt++;
      if (wakeReq === 1'b1) wakeCnt++;
      if (cycCnt == LIMIT) begin
         errorCnt++;
         finishTest();
      end
   end

   task automatic finishTest();
      $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
      if (errorCnt == 0 && cmpCount > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Writable bits of each register
   function automatic logic [23:0] msk(input int a);
      case (a)
         1: msk = CFG_MASK;
         2: msk = HIZP_MASK;
         3: msk = HIZG_MASK;
         7: msk = WET_GH_MASK;
         8: msk = WET_PH_MASK;
         default: msk = WET_FULL;
      endcase
   endfunction

   // Expected one-hot current select of one channel
   function automatic logic [7:0] sel(input int ch, input bit gnd);
      int   ri;
      logic hz;
      ri = gnd ? 5 + ch / 8 : (ch < 8 ? 4 : 8);
      hz = gnd ? regv[3][ch] : regv[2][ch];
      sel = hz ? 8'h00 : 8'h01 << regv[ri][3*(ch%8)+:3];
   endfunction

   task automatic wr(input int a, input logic [23:0] d);
      mst.xfer({a[6:0], 1'b1, d}, 32, rsp);
   endtask

   // Chained reads: each frame returns the previous address
   task automatic readAll();
      mst.xfer({7'h01, 25'h0}, 32, rsp);
      for (int a = 2; a <= 9; a++) begin
         mst.xfer({(a == 9) ? ADDR_CHECK : 7'(a), 25'h0}, 32, rsp);
         check(rsp, 32'(regv[a-1]));
      end
   endtask

   task automatic checkOuts();
      check(32'(ovGuardOff), 32'(regv[1][16]));
      check(32'(muxSource), 32'(regv[1][13:12]));
      check(32'(polarity), 32'(regv[1][11:0]));
      for (int k = 0; k < NUM_GND; k++) begin
         if (k < NUM_PROG)
            check(32'(progSrcSel[8*k+:8]), 32'(sel(k, 0)));
         check(32'(gndSrcSel[8*k+:8]), 32'(sel(k, 1)));
      end
   endtask

   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      irqEvent = 1'b0;
      faultEvent = 1'b0;
      faultPresent = 1'b0;
      lowPowerMode = 1'b0;
      logicRailOk = 1'b1;
      wakePin_n = 1'b1;
      pollWindow = 1'b0;
      regv[1] = CFG_RESET;
      regv[2] = HIZP_MASK;
      regv[3] = HIZG_MASK;
      for (int a = 4; a <= 8; a++) regv[a] = WET_RESET & msk(a);
      void'($urandom(32'hDB2F0899));
      repeat (12) @(posedge clk);
      check(32'(misoOe), 32'd0);
      check(32'(irqPin_n), 32'd1);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      checkOuts();
      readAll();
      // Random contents, every mux code, ones in unused bits
      for (int r = 0; r < 4; r++) begin
         for (int a = 1; a <= 8; a++) begin
            regv[a] = 24'($urandom()) & msk(a);
            if (a == 1) regv[1][13:12] = r[1:0];
            wr(a, regv[a] | ~msk(a));
         end
         repeat (8) @(posedge clk);
         checkOuts();
         if (r < 2) readAll();
      end
      // Unmapped address reads zero, check word comes next frame
      mst.xfer({7'h10, 25'h0}, 32, rsp);
      mst.xfer({ADDR_CHECK, 25'h0}, 32, rsp);
      check(rsp, 32'h0);
      mst.xfer({ADDR_CHECK, 25'h0}, 32, rsp);
      check(rsp, 32'(CHECK_WORD));
      // A frame one bit short must leave the register alone
      mst.xfer({ADDR_HIZ_PROG, 1'b1, ~regv[2]}, 31, rsp);
      mst.xfer({ADDR_HIZ_PROG, 25'h0}, 32, rsp);
      mst.xfer({ADDR_CHECK, 25'h0}, 32, rsp);
      check(rsp, 32'(regv[2]));
      // Wake with rail check on; a write in low power is refused
      regv[1][15] = 1'b1;
      regv[1][14] = 1'b0;
      wr(1, regv[1]);
      lowPowerMode <= 1'b1;
      wr(1, regv[1] ^ 24'h00C000);
      logicRailOk <= 1'b0;
      wakePin_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(32'(wakeCnt), 32'd1);
      pollWindow <= 1'b1;
      repeat (10) @(posedge clk);
      pollWindow <= 1'b0;
      repeat (10) @(posedge clk);
      check(32'(pollSample[11:0]), 32'(regv[2][11:0]));
      check(32'(pollSample[32:12]), 32'(regv[3][20:0]));
      wakePin_n <= 1'b1;
      lowPowerMode <= 1'b0;
      regv[1][15] = 1'b0;
      wr(1, regv[1]);
      lowPowerMode <= 1'b1;
      repeat (10) @(posedge clk);
      wakePin_n <= 1'b0;
      repeat (10) @(posedge clk);
      check(32'(wakeCnt), 32'd1);
      wakePin_n <= 1'b1;
      lowPowerMode <= 1'b0;
      // Latched interrupt: the check word frame must not clear it
      irqEvent <= 1'b1;
      @(posedge clk) irqEvent <= 1'b0;
      repeat (6) @(posedge clk);
      check(32'(irqPin_n), 32'd0);
      mst.xfer({ADDR_CHECK, 25'h0}, 32, rsp);
      check(32'(irqPin_n), 32'd0);
      mst.xfer({ADDR_HIZ_PROG, 25'h0}, 32, rsp);
      check(32'(irqPin_n), 32'd1);
      // Pulsed interrupt returns high on its own
      regv[1][14] = 1'b1;
      wr(1, regv[1]);
      irqEvent <= 1'b1;
      @(posedge clk) irqEvent <= 1'b0;
      repeat (3) @(posedge clk);
      check(32'(irqPin_n), 32'd0);
      repeat (PULSE + 4) @(posedge clk);
      check(32'(irqPin_n), 32'd1);
      // Fault flag survives a read while the fault stands
      faultPresent <= 1'b1;
      faultEvent <= 1'b1;
      @(posedge clk) faultEvent <= 1'b0;
      mst.xfer({ADDR_FAULT_STAT, 25'h0}, 32, rsp);
      faultPresent <= 1'b0;
      mst.xfer({ADDR_FAULT_STAT, 25'h0}, 32, rsp);
      check(rsp, 32'h00C00000);
      mst.xfer({ADDR_FAULT_STAT, 25'h0}, 32, rsp);
      check(rsp, 32'h00800000);
      mst.xfer({ADDR_CHECK, 25'h0}, 32, rsp);
      check(rsp, 32'h00000000);
      finishTest();
   end
endmodule

`default_nettype wire

/* File: tb/swc_spi_master.sv */
// Serial master model standing in for the controller.
// Assumes the core clock paces it: 16 clocks high (80 ns), 17 clocks low (85 ns).
`default_nettype none

module swc_spi_master (
   input  wire logic clk,      // Core clock
   input  wire logic misoOut,  // Data from device
   output logic      sclkPin,  // Serial clock, idles low
   output logic      csPin_n,  // Chip select, active low
   output logic      mosiPin   // Serial data to device
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////
   // Idle levels at time zero
   initial begin
      sclkPin = 1'b0;
      csPin_n = 1'b1;
      mosiPin = 1'b0;
   end

   // One frame, MSB first; data moves after the falling edge
   task automatic xfer(input logic [31:0] cmd, input int nBits,
                       output logic [31:0] rsp);
      rsp = '0;
      @(posedge clk) csPin_n <= 1'b0;
      for (int i = 0; i < nBits; i++) begin
         @(posedge clk) mosiPin <= cmd[31-i];
         repeat (16) @(posedge clk);
         sclkPin <= 1'b1;
         rsp = {rsp[30:0], misoOut};
         repeat (16) @(posedge clk);
         sclkPin <= 1'b0;
      end
      repeat (16) @(posedge clk);
      csPin_n <= 1'b1;
      // Released data line must not keep its last value
      mosiPin <= ~mosiPin;
      repeat (8) @(posedge clk);
   endtask
endmodule

`default_nettype wire

/* File: verilog/swc_config_regs.sv */
// Serial-reached configuration registers for a switch detection front end.
// Assumes a mode-0 serial master; link pins are sampled by the core clock.
//
// Behaviour
// - Frame: address 31-25, write flag 24, data.
// - Config bit 16 set turns overvoltage guard off.
// - Bit 15 low: ignore wake pin, rail low.
// - Bit 15 high: wake on falling edge; resets one.
// - Bit 14 picks latched or pulsed interrupt pin.
// - Bits 13-12 choose analog mux source.
// - Bits 11-0 set input polarity, reset ones.
// - High-impedance bit disables current source only.
// - High-impedance bits all reset to one.
// - Low power polls high-Z inputs, decide at window end.
// - High-impedance registers at addresses two and three.
// - Lower level registers pack eight 3-bit fields each.
// - Upper level registers hold four and five fields.
// - Level codes map to eight current steps.
// - Every level field resets to sixteen milliamps.
// - Writes accepted any time in normal mode.
// - Response bits 23 and 22 carry summary flags.
// - Any flagged register transaction clears interrupt flag.
// - Fault flag clears on fault read if cleared.
`default_nettype none

module swc_config_regs
   import swc_pkg::*;
#(
   parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES
)(
   input  wire logic              clk,          // Core clock 200 MHz
   input  wire logic              reset_n,      // Async reset, active low
   input  wire logic              sclkPin,      // Serial clock from master
   input  wire logic              csPin_n,      // Chip select, active low
   input  wire logic              mosiPin,      // Serial data in
   output logic                   misoOut,      // Serial data out
   output logic                   misoOe,       // Drive enable for data out
   input  wire logic              faultEvent,   // Fault detected pulse
   input  wire logic              faultPresent, // Fault still present
   input  wire logic              irqEvent,     // Interrupt event pulse
   input  wire logic              lowPowerMode, // Device in low power
   input  wire logic              logicRailOk,  // Logic supply rail up
   input  wire logic              wakePin_n,    // Wake request pin
   input  wire logic              pollWindow,   // Active poll window level
   output logic                   wakeReq,      // Wake request pulse
   output logic                   irqPin_n,     // Interrupt pin, active low
   output logic                   ovGuardOff,   // Overvoltage guard off
   output logic [1:0]             muxSource,    // Analog mux source
   output logic [NUM_PROG-1:0]    polarity,     // 1 switch-to-battery
   output logic [8*NUM_PROG-1:0]  progSrcSel,   // Per-input current select
   output logic [8*NUM_GND-1:0]   gndSrcSel,    // Per-input current select
   output logic [NUM_PROG+NUM_GND-1:0] pollSample // Sampled at window end
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic sclkS, csS_n, mosiS, wakeS_n, railS, pollS;
   logic csSel, wakeLow;

   // Active-low pins pass inverted so the flops' reset level matches the
   // idle pin; otherwise a false select and a false wake edge follow reset
   swc_sync uSyncSclk (.clk(clk), .reset_n(reset_n), .asyncIn(sclkPin),
                       .syncOut(sclkS));
   swc_sync uSyncCs   (.clk(clk), .reset_n(reset_n), .asyncIn(~csPin_n),
                       .syncOut(csSel));
   swc_sync uSyncMosi (.clk(clk), .reset_n(reset_n), .asyncIn(mosiPin),
                       .syncOut(mosiS));
   swc_sync uSyncWake (.clk(clk), .reset_n(reset_n), .asyncIn(~wakePin_n),
                       .syncOut(wakeLow));
   swc_sync uSyncRail (.clk(clk), .reset_n(reset_n), .asyncIn(logicRailOk),
                       .syncOut(railS));
   swc_sync uSyncPoll (.clk(clk), .reset_n(reset_n), .asyncIn(pollWindow),
                       .syncOut(pollS));

   assign csS_n   = ~csSel;
   assign wakeS_n = ~wakeLow;

   ////////////////////////////////////////////////////////////////////////
   // Edge detection on synchronised levels

   logic sclkD_q, csD_q, wakeD_q, pollD_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclkD_q <= 1'b0;
         csD_q   <= 1'b1;
         wakeD_q <= 1'b1;
         pollD_q <= 1'b0;
      end else begin
         sclkD_q <= sclkS;
         csD_q   <= csS_n;
         wakeD_q <= wakeS_n;
         pollD_q <= pollS;
      end
   end

   logic sclkRise, sclkFall, csStart, csEnd, wakeFall, pollEnd;
   assign sclkRise = sclkS & ~sclkD_q;
   assign sclkFall = ~sclkS & sclkD_q;
   assign csStart  = ~csS_n & csD_q;
   assign csEnd    = csS_n & ~csD_q;
   assign wakeFall = ~wakeS_n & wakeD_q;
   assign pollEnd  = ~pollS & pollD_q;

   ////////////////////////////////////////////////////////////////////////
   // Frame shifter and bit counter

   logic [FRAME_BITS-1:0] shiftIn_q;
   logic [5:0]            bitCnt_q;

   // Sample on rising serial clock while selected
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shiftIn_q <= '0;
         bitCnt_q  <= 6'h00;
      end else if (csStart) begin
         bitCnt_q <= 6'h00;
      end else if (!csS_n && sclkRise) begin
         shiftIn_q <= {shiftIn_q[FRAME_BITS-2:0], mosiS};
         if (bitCnt_q != 6'h3F) begin
            bitCnt_q <= bitCnt_q + 6'h01; // Saturate so long frames fail
         end
      end
   end

   logic [6:0]  frmAddr;
   logic        frmWrite;
   logic [23:0] frmData;
   logic        frameOk;
   assign frmAddr  = shiftIn_q[ADDR_MSB:ADDR_LSB];
   assign frmWrite = shiftIn_q[RW_BIT];
   assign frmData  = shiftIn_q[DATA_BITS-1:0];
   assign frameOk  = csEnd && (bitCnt_q == 6'(FRAME_BITS));

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   logic [23:0] cfg_q, hizP_q, hizG_q;
   logic [23:0] wetPL_q, wetGL_q, wetGM_q, wetGH_q, wetPH_q;

   // Writes only on a complete frame, masked to implemented bits
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q   <= CFG_RESET;
         hizP_q  <= HIZP_MASK;
         hizG_q  <= HIZG_MASK;
         wetPL_q <= WET_RESET;
         wetGL_q <= WET_RESET;
         wetGM_q <= WET_RESET;
         wetGH_q <= WET_RESET & WET_GH_MASK;
         wetPH_q <= WET_RESET & WET_PH_MASK;
      end else if (frameOk && frmWrite && !lowPowerMode) begin
         case (frmAddr)
            ADDR_CONFIG:    cfg_q   <= frmData & CFG_MASK;
            ADDR_HIZ_PROG:  hizP_q  <= frmData & HIZP_MASK;
            ADDR_HIZ_GND:   hizG_q  <= frmData & HIZG_MASK;
            ADDR_WET_PLOW:  wetPL_q <= frmData;
            ADDR_WET_GLOW:  wetGL_q <= frmData;
            ADDR_WET_GMID:  wetGM_q <= frmData;
            ADDR_WET_GHIGH: wetGH_q <= frmData & WET_GH_MASK;
            ADDR_WET_PHIGH: wetPH_q <= frmData & WET_PH_MASK;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovGuardOff <= 1'b0;
         muxSource  <= 2'h0;
         polarity   <= '1;
      end else begin
         ovGuardOff <= cfg_q[CFG_OV_OFF_BIT];
         muxSource  <= cfg_q[CFG_MUX_MSB:CFG_MUX_LSB];
         polarity   <= cfg_q[CFG_POL_MSB:0];
      end
   end

   // Wake pin honoured only when checking is on or the rail is up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeReq <= 1'b0;
      end else begin
         wakeReq <= lowPowerMode && wakeFall &&
                    (cfg_q[CFG_WAKE_CHK] || railS);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-input current source decode

   logic [3*NUM_PROG-1:0] progLevels;
   logic [3*NUM_GND-1:0]  gndLevels;
   assign progLevels = {wetPH_q[11:0], wetPL_q};
   assign gndLevels  = {wetGH_q[14:0], wetGM_q, wetGL_q};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PROG; gi++) begin : gProg
         swc_wet_decode uDec (.clk(clk), .reset_n(reset_n),
            .level(progLevels[3*gi +: 3]), .highZ(hizP_q[gi]),
            .srcSel(progSrcSel[8*gi +: 8]));
      end
      for (gi = 0; gi < NUM_GND; gi++) begin : gGnd
         swc_wet_decode uDec (.clk(clk), .reset_n(reset_n),
            .level(gndLevels[3*gi +: 3]), .highZ(hizG_q[gi]),
            .srcSel(gndSrcSel[8*gi +: 8]));
      end
   endgenerate

   // Comparators stay live; state is captured at the end of the window
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pollSample <= '0;
      end else if (lowPowerMode && pollEnd) begin
         pollSample <= {hizG_q[NUM_GND-1:0], hizP_q[NUM_PROG-1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Summary flags

   logic faultFlag_q, irqFlag_q, flagRegHit;
   assign flagRegHit = frameOk && (frmAddr != ADDR_CHECK) &&
                       (frmAddr != ADDR_WET_PLOW) &&
                       (frmAddr != ADDR_WET_GLOW) &&
                       (frmAddr != ADDR_WET_GMID);

   // Set wins over clear so no event is lost
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqFlag_q   <= 1'b0;
         faultFlag_q <= 1'b0;
      end else begin
         if (irqEvent) begin
            irqFlag_q <= 1'b1;
         end else if (flagRegHit) begin
            irqFlag_q <= 1'b0;
         end
         if (faultEvent) begin
            faultFlag_q <= 1'b1;
         end else if (frameOk && !frmWrite && frmAddr == ADDR_FAULT_STAT
                      && !faultPresent) begin
            faultFlag_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt pin: latched until flag clears, or a timed pulse

   logic [15:0] pulseCnt_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pulseCnt_q <= 16'h0000;
      end else if (irqEvent && cfg_q[CFG_IRQ_PULSE]) begin
         pulseCnt_q <= 16'(PULSE_CYCLES);
      end else if (pulseCnt_q != 16'h0000) begin
         pulseCnt_q <= pulseCnt_q - 16'h0001;
      end
   end

   assign irqPin_n = cfg_q[CFG_IRQ_PULSE] ? (pulseCnt_q == 16'h0000)
                                          : ~irqFlag_q;

   ////////////////////////////////////////////////////////////////////////
   // Response word: loaded at frame start, shifted on falling clock

   logic [23:0] rdData;
   logic        hasFlags;
   always_comb begin
      rdData   = 24'h000000;
      hasFlags = 1'b1;
      case (frmAddr)
         ADDR_CHECK:     begin rdData = CHECK_WORD; hasFlags = 1'b0; end
         ADDR_CONFIG:    rdData = cfg_q;
         ADDR_HIZ_PROG:  rdData = hizP_q;
         ADDR_HIZ_GND:   rdData = hizG_q;
         ADDR_WET_PLOW:  begin rdData = wetPL_q; hasFlags = 1'b0; end
         ADDR_WET_GLOW:  begin rdData = wetGL_q; hasFlags = 1'b0; end
         ADDR_WET_GMID:  begin rdData = wetGM_q; hasFlags = 1'b0; end
         ADDR_WET_GHIGH: rdData = wetGH_q;
         ADDR_WET_PHIGH: rdData = wetPH_q;
         default:        rdData = 24'h000000;
      endcase
      if (hasFlags) begin
         rdData[FAULT_BIT] = faultFlag_q;
         rdData[IRQ_BIT]   = irqFlag_q;
      end
   end

   // Previous frame's address selects the answer for the next frame
   logic [FRAME_BITS-1:0] shiftOut_q;
   logic [23:0]           nextWord_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nextWord_q <= 24'h000000;
      end else if (frameOk) begin
         nextWord_q <= rdData;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shiftOut_q <= '0;
      end else if (csStart) begin
         shiftOut_q <= {8'h00, nextWord_q};
      end else if (!csS_n && sclkFall) begin
         shiftOut_q <= {shiftOut_q[FRAME_BITS-2:0], 1'b0};
      end
   end

   assign misoOut = shiftOut_q[FRAME_BITS-1];
   assign misoOe  = ~csS_n;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_frame_len;
      @(posedge clk) disable iff (!reset_n)
      frameOk |-> bitCnt_q == 6'd32;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("commit on wrong frame length");

   property p_cfg_write;
      @(posedge clk) disable iff (!reset_n)
      (frameOk && frmWrite && !lowPowerMode && frmAddr == ADDR_CONFIG)
      |=> cfg_q == ($past(frmData) & CFG_MASK);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("config write lost");

   property p_ov;
      @(posedge clk) disable iff (!reset_n)
      ##1 ovGuardOff == $past(cfg_q[CFG_OV_OFF_BIT]);
   endproperty
   a_ov: assert property (p_ov) else $error("guard mismatch");

   property p_wake_ignore;
      @(posedge clk) disable iff (!reset_n)
      (!cfg_q[CFG_WAKE_CHK] && !railS) |=> !wakeReq;
   endproperty
   a_wake_ignore: assert property (p_wake_ignore)
      else $error("wake not ignored");

   property p_wake_edge;
      @(posedge clk) disable iff (!reset_n)
      (lowPowerMode && wakeFall && cfg_q[CFG_WAKE_CHK]) |=> wakeReq;
   endproperty
   a_wake_edge: assert property (p_wake_edge)
      else $error("wake missed");

   property p_irq_latch;
      @(posedge clk) disable iff (!reset_n)
      (!cfg_q[CFG_IRQ_PULSE] && irqFlag_q) |-> !irqPin_n;
   endproperty
   a_irq_latch: assert property (p_irq_latch)
      else $error("latched pin high");

   property p_irq_clear;
      @(posedge clk) disable iff (!reset_n)
      (flagRegHit && !irqEvent) |=> !irqFlag_q;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("irq flag not cleared");

   property p_fault_hold;
      @(posedge clk) disable iff (!reset_n)
      (faultFlag_q && !(frameOk && !frmWrite &&
                        frmAddr == ADDR_FAULT_STAT && !faultPresent))
      |=> faultFlag_q;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault flag dropped");

   sequence s_hiz_held;
      hizP_q[0] ##1 hizP_q[0];
   endsequence
   property p_hiz_off;
      @(posedge clk) disable iff (!reset_n)
      s_hiz_held |-> progSrcSel[7:0] == 8'h00;
   endproperty
   a_hiz_off: assert property (p_hiz_off)
      else $error("source on in high-Z");

endmodule

`default_nettype wire

/* File: verilog/swc_pkg.sv */
// Package for the switch input configuration register bank.
// Assumes a single 200 MHz core clock; the serial link is sampled by it.
`default_nettype none

package swc_pkg;

   // Serial frame layout
   localparam int FRAME_BITS  = 32;
   localparam int ADDR_MSB    = 31;
   localparam int ADDR_LSB    = 25;
   localparam int RW_BIT      = 24;
   localparam int DATA_BITS   = 24;

   // Register addresses (7-bit)
   localparam logic [6:0] ADDR_CHECK      = 7'h00;
   localparam logic [6:0] ADDR_CONFIG     = 7'h01;
   localparam logic [6:0] ADDR_HIZ_PROG   = 7'h02;
   localparam logic [6:0] ADDR_HIZ_GND    = 7'h03;
   localparam logic [6:0] ADDR_WET_PLOW   = 7'h04;
   localparam logic [6:0] ADDR_WET_GLOW   = 7'h05;
   localparam logic [6:0] ADDR_WET_GMID   = 7'h06;
   localparam logic [6:0] ADDR_WET_GHIGH  = 7'h07;
   localparam logic [6:0] ADDR_WET_PHIGH  = 7'h08;
   localparam logic [6:0] ADDR_FAULT_STAT = 7'h21;

   // Response flag positions
   localparam int FAULT_BIT = 23;
   localparam int IRQ_BIT   = 22;

   // Configuration field positions
   localparam int CFG_OV_OFF_BIT  = 16;
   localparam int CFG_WAKE_CHK    = 15;
   localparam int CFG_IRQ_PULSE   = 14;
   localparam int CFG_MUX_MSB     = 13;
   localparam int CFG_MUX_LSB     = 12;
   localparam int CFG_POL_MSB     = 11;

   // Writable masks and reset values
   localparam logic [23:0] CFG_MASK     = 24'h01FFFF;
   localparam logic [23:0] CFG_RESET    = 24'h008FFF;
   localparam logic [23:0] HIZP_MASK    = 24'h000FFF;
   localparam logic [23:0] HIZG_MASK    = 24'h1FFFFF;
   localparam logic [23:0] WET_FULL     = 24'hFFFFFF;
   localparam logic [23:0] WET_GH_MASK  = 24'h007FFF;
   localparam logic [23:0] WET_PH_MASK  = 24'h000FFF;
   localparam logic [23:0] WET_RESET    = 24'hDB6DB6;
   localparam logic [23:0] CHECK_WORD   = 24'h123456;

   // Wetting level codes
   localparam logic [2:0] WET_16MA = 3'h6;
   localparam int NUM_PROG = 12;
   localparam int NUM_GND  = 21;

   // Analog mux source codes
   typedef enum logic [1:0] {
      MUX_SERIAL_A, MUX_SERIAL_B, MUX_HW2, MUX_HW3
   } swc_mux_e;

   // Interrupt pulse width when pulse style is chosen
   localparam int IRQ_PULSE_NS     = 1000;
   localparam int CLK_PERIOD_NS    = 5;
   localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* File: verilog/swc_sync.sv */
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is the core clock.
`default_nettype none

module swc_sync
   import swc_pkg::*;
(
   input  wire logic clk,      // Core clock
   input  wire logic reset_n,  // Async reset, active low
   input  wire logic asyncIn,  // Level from outside the domain
   output logic      syncOut   // Synchronised level
);

   logic stage1Q;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1Q <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1Q <= asyncIn;
         syncOut <= stage1Q;
      end
   end

endmodule

`default_nettype wire

/* File: verilog/swc_wet_decode.sv */
// Decode of one 3-bit wetting level into a one-hot current selection.
// Assumes the analog side takes one select line per level.
`default_nettype none

module swc_wet_decode
   import swc_pkg::*;
(
   input  wire logic       clk,      // Core clock
   input  wire logic       reset_n,  // Async reset, active low
   input  wire logic [2:0] level,    // Level code
   input  wire logic       highZ,    // Input is high impedance
   output logic      [7:0] srcSel    // One-hot: 2,6,8,10,12,14,16,20 mA
);

   // High impedance forces the source off whatever the level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         srcSel <= 8'h00;
      end else if (highZ) begin
         srcSel <= 8'h00;
      end else begin
         srcSel <= 8'h01 << level;
      end
   end

endmodule

`default_nettype wire
